// ==== ewsg_ext_device.sv ====
// External memory or I/O device model standing on the far side of the bus.
// Assumes the bus cycle is seen as busy; ready is sampled by the core clock.
`timescale 1ns/100ps

module ewsg_ext_device (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	// Bus cycle seen from the device side
	input  wire logic       busy_in,
	input  wire logic [4:0] need_in,
	// Ready back to the core
	output logic            ready_out
);
	logic [4:0] busy_cnt_r;
	logic       idle_pat_r;

	// ==================================================
	// Cycles spent inside the current bus cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_cnt_r <= 5'h00;
		end else if (!busy_in) begin
			busy_cnt_r <= 5'h00;
		end else if (busy_cnt_r != 5'h1F) begin
			busy_cnt_r <= busy_cnt_r + 5'h01;
		end
	end

	// Idle pattern, so nothing can lean on a stale ready level
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			idle_pat_r <= 1'b0;
		end else begin
			idle_pat_r <= ~idle_pat_r;
		end
	end

	// ==================================================
	// Slow device holds ready low until its own access time is reached
	always_comb begin
		if (!busy_in) begin
			ready_out = idle_pat_r;
		end else if (need_in == 5'h00) begin
			ready_out = 1'b1;
		end else begin
			ready_out = (busy_cnt_r >= (need_in - 5'h01));
		end
	end

endmodule

// ==== ewsg_pkg.sv ====
// Constants for the external bus wait-state generator.
// Assumes a single core clock domain and a plain register port.

package ewsg_pkg;

	// ==================================================
	// Widths
	localparam int EWSG_AW  = 8;  // Register port address width
	localparam int EWSG_DW  = 16; // Register width
	localparam int EWSG_PAW = 20; // Extended program address width
	localparam int EWSG_FW  = 3;  // One region field
	localparam int EWSG_CW  = 4;  // Effective count, up to 14

	// ==================================================
	// Register offsets
	localparam logic [EWSG_AW-1:0] EWSG_OFS_REGION = 8'h28;
	localparam logic [EWSG_AW-1:0] EWSG_OFS_MULT   = 8'h2B;

	// ==================================================
	// Field positions
	localparam int EWSG_XPA_BIT = 15;
	localparam int EWSG_IO_LSB  = 12;
	localparam int EWSG_DHI_LSB = 9;
	localparam int EWSG_DLO_LSB = 6;
	localparam int EWSG_PHI_LSB = 3;
	localparam int EWSG_PLO_LSB = 0;
	localparam int EWSG_DBL_BIT = 0;
	localparam int EWSG_HALF_BIT = 15; // Upper or lower half of a 64K page

	// ==================================================
	// Values after reset
	localparam logic [EWSG_DW-1:0] EWSG_REGION_RST = 16'h7FFF;
	localparam logic [EWSG_DW-1:0] EWSG_MULT_RST   = 16'h0000;

	// ==================================================
	// Access space codes
	localparam logic [1:0] EWSG_SP_PROG = 2'h0;
	localparam logic [1:0] EWSG_SP_DATA = 2'h1;
	localparam logic [1:0] EWSG_SP_IO   = 2'h2;

endpackage

// ==== ewsg_top.sv ====
// External bus wait-state generator: region registers and access timing.
// Assumes the core issues one access at a time and ready is synchronous.
`timescale 1ns/100ps

module ewsg_top (
	// Clock and reset
	input  wire logic                         SYS_CLK_IN,
	input  wire logic                         ARST_N_IN,
	// Register port
	input  wire logic [ewsg_pkg::EWSG_AW-1:0]  REG_ADDR_IN,
	input  wire logic [ewsg_pkg::EWSG_DW-1:0]  REG_WDATA_IN,
	input  wire logic                         REG_WR_IN,
	input  wire logic                         REG_RD_IN,
	output logic      [ewsg_pkg::EWSG_DW-1:0]  REG_RDATA_OUT,
	// Core access request
	input  wire logic                         ACC_START_IN,
	input  wire logic [1:0]                   ACC_SPACE_IN,
	input  wire logic [ewsg_pkg::EWSG_PAW-1:0] ACC_ADDR_IN,
	// External ready
	input  wire logic                         READY_IN,
	// Access status
	output logic                              ACC_BUSY_OUT,
	output logic                              ACC_DONE_OUT,
	output logic      [ewsg_pkg::EWSG_CW-1:0]  WAIT_COUNT_OUT,
	output logic                              WSG_CLK_ACTIVE_OUT
);
	import ewsg_pkg::*;

	// ==================================================
	// Register state
	logic [EWSG_DW-1:0] region_wait_select_r;
	logic               wait_count_doubler_r;
	logic               region_written_r;

	// ==================================================
	// Decoded fields
	logic               extended_program_range_select;
	logic [EWSG_FW-1:0] io_field;
	logic [EWSG_FW-1:0] data_hi_field;
	logic [EWSG_FW-1:0] data_lo_field;
	logic [EWSG_FW-1:0] prog_hi_field;
	logic [EWSG_FW-1:0] prog_lo_field;

	// ==================================================
	// Access path
	logic               sel_region;
	logic               sel_mult;
	logic [EWSG_FW-1:0] base_sel;
	logic [EWSG_CW-1:0] eff_count;
	logic               acc_take;
	logic               all_zero;
	logic               ctr_busy;
	logic               ctr_done;
	logic [EWSG_DW-1:0] rdata_nxt;

	// Address decode of the register port
	assign sel_region = (REG_ADDR_IN == EWSG_OFS_REGION);
	assign sel_mult   = (REG_ADDR_IN == EWSG_OFS_MULT);

	// Field views of the region register
	assign extended_program_range_select = region_wait_select_r[EWSG_XPA_BIT];
	assign io_field      = region_wait_select_r[EWSG_IO_LSB +: EWSG_FW];
	assign data_hi_field = region_wait_select_r[EWSG_DHI_LSB +: EWSG_FW];
	assign data_lo_field = region_wait_select_r[EWSG_DLO_LSB +: EWSG_FW];
	assign prog_hi_field = region_wait_select_r[EWSG_PHI_LSB +: EWSG_FW];
	assign prog_lo_field = region_wait_select_r[EWSG_PLO_LSB +: EWSG_FW];

	// ==================================================
	// Region wait register
	// Reset value gives seven waits in every region
	// Writes land whole; the range select is an ordinary stored bit
	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			region_wait_select_r <= EWSG_REGION_RST;
		end else if (REG_WR_IN && sel_region) begin
			region_wait_select_r <= REG_WDATA_IN;
		end
	end

	// Marks that software has taken over the region fields
	// Read only by the reset check below; it costs one flip-flop
	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			region_written_r <= 1'b0;
		end else if (REG_WR_IN && sel_region) begin
			region_written_r <= 1'b1;
		end
	end

	// ==================================================
	// Multiplier control register
	// Only the doubler bit is stored; upper bits have no flip-flops
	// Writes to bits 15..1 vanish, so they always read back as zero
	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			wait_count_doubler_r <= EWSG_MULT_RST[EWSG_DBL_BIT];
		end else if (REG_WR_IN && sel_mult) begin
			wait_count_doubler_r <= REG_WDATA_IN[EWSG_DBL_BIT];
		end
	end

	// ==================================================
	// Read data mux
	// Unmapped offsets read as zero
	always_comb begin
		rdata_nxt = '0;
		if (sel_region) begin
			rdata_nxt = region_wait_select_r;
		end else if (sel_mult) begin
			rdata_nxt[EWSG_DBL_BIT] = wait_count_doubler_r;
		end
	end

	// Read data stand only in the cycle after the strobe
	// Zero otherwise, so a stale word is never taken for a fresh one
	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			REG_RDATA_OUT <= '0;
		end else if (REG_RD_IN) begin
			REG_RDATA_OUT <= rdata_nxt;
		end else begin
			REG_RDATA_OUT <= '0;
		end
	end

	// ==================================================
	// Region select
	// An illegal space code falls back to the I/O field, the safe choice
	// Only address bit 15 matters; page bits above it select nothing
	always_comb begin
		base_sel = io_field;
		unique case (ACC_SPACE_IN)
			EWSG_SP_IO: begin
				base_sel = io_field;
			end
			EWSG_SP_DATA: begin
				if (ACC_ADDR_IN[EWSG_HALF_BIT]) begin
					base_sel = data_hi_field;
				end else begin
					base_sel = data_lo_field;
				end
			end
			EWSG_SP_PROG: begin
				if (extended_program_range_select) begin
					base_sel = prog_lo_field;
				end else if (ACC_ADDR_IN[EWSG_HALF_BIT]) begin
					base_sel = prog_hi_field;
				end else begin
					base_sel = prog_lo_field;
				end
			end
			default: begin
				base_sel = io_field;
			end
		endcase
	end

	// Scaling by one or two; the doubled value tops out at 14
	assign eff_count = wait_count_doubler_r ? {base_sel, 1'b0} : {1'b0, base_sel};

	// New access accepted only when the previous one has finished
	// A start met while busy is dropped; the core must wait for done
	assign acc_take = ACC_START_IN && !ctr_busy;

	// ==================================================
	// Effective count latch
	// Held until the next taken access, for the core's bus timing
	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			WAIT_COUNT_OUT <= '0;
		end else if (acc_take) begin
			WAIT_COUNT_OUT <= eff_count;
		end
	end

	// ==================================================
	// Clock gating request
	// Upper program field counts only while the range select is clear
	assign all_zero = (io_field == '0) && (data_hi_field == '0) && (data_lo_field == '0) &&
		(prog_lo_field == '0) && (extended_program_range_select || prog_hi_field == '0);

	// Drives the enable of the generator's clock gate cell
	// Gating saves power only; access timing is the same either way
	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			WSG_CLK_ACTIVE_OUT <= 1'b1;
		end else begin
			WSG_CLK_ACTIVE_OUT <= !all_zero;
		end
	end

	// ==================================================
	// Wait counter
	// The counter sees every start but acts only while idle,
	// which is exactly the condition of acc_take above
	ewsg_wait_counter #(
		.CW        (EWSG_CW)
	) u_counter (
		.clk_in    (SYS_CLK_IN),
		.arst_n_in (ARST_N_IN),
		.start_in  (ACC_START_IN),
		.count_in  (eff_count),
		.ready_in  (READY_IN),
		.busy_out  (ctr_busy),
		.done_out  (ctr_done)
	);

	// Counter flags are already flip-flops
	assign ACC_BUSY_OUT = ctr_busy;
	assign ACC_DONE_OUT = ctr_done;

	// ==================================================
	// Checks on region selection
	// Each access check looks one edge after the take, at the latched count
	sequence s_take_plain;
		acc_take && !wait_count_doubler_r;
	endsequence

	a_xpa_write_held: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(REG_WR_IN && sel_region) |=> extended_program_range_select == $past(REG_WDATA_IN[EWSG_XPA_BIT]))
		else $error("range select bit not stored from write");

	a_io_region: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(s_take_plain and ACC_SPACE_IN == EWSG_SP_IO) |=>
		WAIT_COUNT_OUT == {1'b0, $past(region_wait_select_r[14:12])})
		else $error("I/O access took wrong field");

	a_data_upper: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(s_take_plain and ACC_SPACE_IN == EWSG_SP_DATA && ACC_ADDR_IN[15]) |=>
		WAIT_COUNT_OUT == {1'b0, $past(region_wait_select_r[11:9])})
		else $error("upper data access took wrong field");

	a_data_lower: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(s_take_plain and ACC_SPACE_IN == EWSG_SP_DATA && !ACC_ADDR_IN[15]) |=>
		WAIT_COUNT_OUT == {1'b0, $past(region_wait_select_r[8:6])})
		else $error("lower data access took wrong field");

	a_prog_upper: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(s_take_plain and ACC_SPACE_IN == EWSG_SP_PROG && !region_wait_select_r[15] && ACC_ADDR_IN[15])
		|=> WAIT_COUNT_OUT == {1'b0, $past(region_wait_select_r[5:3])})
		else $error("upper program access took wrong field");

	a_prog_hi_ignored: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(s_take_plain and ACC_SPACE_IN == EWSG_SP_PROG && region_wait_select_r[15] && ACC_ADDR_IN[15])
		|=> WAIT_COUNT_OUT == {1'b0, $past(region_wait_select_r[2:0])})
		else $error("upper program field used while range select set");

	a_prog_lower: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(s_take_plain and ACC_SPACE_IN == EWSG_SP_PROG && !region_wait_select_r[15] && !ACC_ADDR_IN[15])
		|=> WAIT_COUNT_OUT == {1'b0, $past(region_wait_select_r[2:0])})
		else $error("lower program access took wrong field");

	a_prog_extended: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(s_take_plain and ACC_SPACE_IN == EWSG_SP_PROG && region_wait_select_r[15]) |=>
		WAIT_COUNT_OUT == {1'b0, $past(region_wait_select_r[2:0])})
		else $error("extended program access took wrong field");

	// ==================================================
	// Checks on scaling and register contents
	// Doubling is a one-bit shift, so odd doubled counts never appear
	a_doubler_scales: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(acc_take && wait_count_doubler_r) |=>
		(WAIT_COUNT_OUT[0] == 1'b0 && WAIT_COUNT_OUT <= 4'hE && WAIT_COUNT_OUT == $past({base_sel, 1'b0})))
		else $error("doubled count wrong");

	a_plain_unscaled: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		s_take_plain |=> WAIT_COUNT_OUT == $past({1'b0, base_sel}))
		else $error("count scaled with doubler clear");

	a_mult_upper_zero: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(REG_RD_IN && sel_mult) |=> REG_RDATA_OUT[15:1] == 15'h0000)
		else $error("multiplier reserved bits not zero");

	a_reset_seven: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(s_take_plain and !region_written_r) |=> WAIT_COUNT_OUT == 4'h7)
		else $error("access after reset not seven waits");

	a_gate_follows: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(REG_WR_IN && sel_region && REG_WDATA_IN == 16'h0000) |=> ##1 !WSG_CLK_ACTIVE_OUT)
		else $error("generator clock not gated with all zero waits");

	a_done_after_busy: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		ACC_DONE_OUT |-> ($past(ACC_BUSY_OUT) && !ACC_BUSY_OUT))
		else $error("done without preceding bus cycle");

	// ==================================================
	// Checks on the access handshake
	// A start that meets a busy counter is dropped without a sign, so the
	// only trace a wrong take would leave is a changed latched count
	sequence s_start_refused;
		ACC_START_IN && ctr_busy;
	endsequence

	a_busy_after_take: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		acc_take |=> (ACC_BUSY_OUT && !ACC_DONE_OUT))
		else $error("bus cycle not raised after access taken");

	a_refused_keeps_count: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		s_start_refused |=> $stable(WAIT_COUNT_OUT))
		else $error("count changed by a start during a bus cycle");

	a_done_single: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		ACC_DONE_OUT |=> !ACC_DONE_OUT)
		else $error("done pulse longer than one cycle");

	// ==================================================
	// Checks on the register port and the gate enable
	sequence s_region_read;
		REG_RD_IN && sel_region;
	endsequence

	a_region_readback: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		s_region_read |=> REG_RDATA_OUT == $past(region_wait_select_r))
		else $error("region register read back wrong");

	a_doubler_write: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(REG_WR_IN && sel_mult) |=> wait_count_doubler_r == $past(REG_WDATA_IN[EWSG_DBL_BIT]))
		else $error("doubler bit not stored from write");

	a_rdata_idle_zero: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		!REG_RD_IN |=> REG_RDATA_OUT == '0)
		else $error("read data held beyond its cycle");

	a_gate_reopens: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
		(REG_WR_IN && sel_region && REG_WDATA_IN[14:6] != 9'h000) |=> ##1 WSG_CLK_ACTIVE_OUT)
		else $error("generator clock gated while a region has waits");

endmodule

// ==== ewsg_top_bench.sv ====
// Self-checking bench for the external bus wait-state generator.
// Assumes ewsg_pkg, ewsg_top and the external device model are compiled first.
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module ewsg_top_bench;
	import ewsg_pkg::*;

	logic                sys_clk;
	logic                arst_n;
	logic [EWSG_AW-1:0]  reg_addr;
	logic [EWSG_DW-1:0]  reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [EWSG_DW-1:0]  reg_rdata;
	logic                acc_start;
	logic [1:0]          acc_space;
	logic [EWSG_PAW-1:0] acc_addr;
	logic                ready;
	logic [4:0]          need;
	logic                acc_busy;
	logic                acc_done;
	logic [EWSG_CW-1:0]  wait_count;
	logic                clk_active;
	int                  bad_count;
	int                  n_compared;

	// ==================================================
	// Clock, 40 ns period
	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;

	ewsg_top dut (
		.SYS_CLK_IN         (sys_clk),
		.ARST_N_IN          (arst_n),
		.REG_ADDR_IN        (reg_addr),
		.REG_WDATA_IN       (reg_wdata),
		.REG_WR_IN          (reg_wr),
		.REG_RD_IN          (reg_rd),
		.REG_RDATA_OUT      (reg_rdata),
		.ACC_START_IN       (acc_start),
		.ACC_SPACE_IN       (acc_space),
		.ACC_ADDR_IN        (acc_addr),
		.READY_IN           (ready),
		.ACC_BUSY_OUT       (acc_busy),
		.ACC_DONE_OUT       (acc_done),
		.WAIT_COUNT_OUT     (wait_count),
		.WSG_CLK_ACTIVE_OUT (clk_active)
	);

	ewsg_ext_device ext (
		.clk_in    (sys_clk),
		.arst_n_in (arst_n),
		.busy_in   (acc_busy),
		.need_in   (need),
		.ready_out (ready)
	);

	// ==================================================
	// Verdict, the single exit of the run
	task automatic complete_run();
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Register port cycles
	task automatic reg_write(input logic [EWSG_AW-1:0] a, input logic [EWSG_DW-1:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_read(input logic [EWSG_AW-1:0] a, output logic [EWSG_DW-1:0] d);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// One access: latched count at done, busy at take and at done, latency in edges
	task automatic access(input logic [1:0] sp, input logic [EWSG_PAW-1:0] a, input logic [4:0] nd,
	                      input logic [EWSG_CW-1:0] exp_n, output logic [EWSG_CW-1:0] got_n, output int edges,
	                      output logic [1:0] busy_seen);
		@(posedge sys_clk);
		acc_start <= 1'b1;
		acc_space <= sp;
		acc_addr  <= a;
		need      <= nd;
		@(posedge sys_clk);
		// Start held one more edge with the other half: a refused request
		acc_addr  <= a ^ 20'h08000;
		#1;
		edges        = 1;
		busy_seen[1] = acc_busy;
		while (acc_done !== 1'b1 && edges < 40) begin
			@(posedge sys_clk);
			acc_start <= 1'b0;
			#1;
			edges++;
		end
		busy_seen[0] = acc_busy;
		got_n        = wait_count;
	endtask

	// Checks count and latency, ready stalls beyond the programmed waits
	task automatic acc_chk(input logic [1:0] sp, input logic [EWSG_PAW-1:0] a, input logic [4:0] nd,
	                       input logic [EWSG_CW-1:0] exp_n);
		logic [EWSG_CW-1:0] got_n;
		int                 edges;
		int                 exp_e;
		logic [1:0]         busy_seen;
		access(sp, a, nd, exp_n, got_n, edges, busy_seen);
		exp_e = ((int'(exp_n) + 1 > int'(nd)) ? int'(exp_n) + 1 : int'(nd)) + 1;
		`CHK("wait_count", exp_n, got_n)
		`CHK("latency", exp_e, edges)
		`CHK("busy_span", 2'b10, busy_seen)
	endtask

	// ==================================================
	// Scenarios
	task automatic sc_reset_state();
		logic [EWSG_DW-1:0] d;
		`CHK("wait_count_reset", 4'h0, wait_count)
		`CHK("busy_reset", 1'b0, acc_busy)
		reg_read(EWSG_OFS_REGION, d);
		`CHK("region_reset", 16'h7FFF, d)
		@(posedge sys_clk);
		#1;
		`CHK("rdata_cleared", 16'h0000, reg_rdata)
		reg_read(EWSG_OFS_MULT, d);
		`CHK("mult_reset", 16'h0000, d)
		`CHK("clk_active_reset", 1'b1, clk_active)
		acc_chk(EWSG_SP_PROG, 20'h18000, 5'h00, 4'h7);
		acc_chk(EWSG_SP_DATA, 20'h00010, 5'h00, 4'h7);
		acc_chk(EWSG_SP_IO, 20'h0FFFF, 5'h00, 4'h7);
	endtask

	// Fields: io 1, data hi 2, data lo 3, prog hi 4, prog lo 5
	task automatic sc_regions(input logic dbl);
		logic [EWSG_CW-1:0] k;
		k = dbl ? 4'h2 : 4'h1;
		reg_write(EWSG_OFS_REGION, 16'h14E5);
		acc_chk(EWSG_SP_IO, 20'h08000, 5'h00, 4'(1 * k));
		acc_chk(EWSG_SP_DATA, 20'h08000, 5'h00, 4'(2 * k));
		acc_chk(EWSG_SP_DATA, 20'h07FFF, 5'h00, 4'(3 * k));
		acc_chk(EWSG_SP_PROG, 20'h38000, 5'h00, 4'(4 * k));
		acc_chk(EWSG_SP_PROG, 20'h27FFF, 5'h00, 4'(5 * k));
		reg_write(EWSG_OFS_REGION, 16'h94E5);
		acc_chk(EWSG_SP_PROG, 20'h38000, 5'h00, 4'(5 * k));
		acc_chk(EWSG_SP_PROG, 20'hFFFFF, 5'h00, 4'(5 * k));
		acc_chk(EWSG_SP_PROG, 20'h00000, 5'h00, 4'(5 * k));
	endtask

	task automatic sc_doubler();
		logic [EWSG_DW-1:0] d;
		reg_write(EWSG_OFS_MULT, 16'hFFFF);
		reg_read(EWSG_OFS_MULT, d);
		`CHK("mult_reserved", 16'h0001, d)
		reg_write(EWSG_OFS_REGION, 16'h7FFF);
		acc_chk(EWSG_SP_DATA, 20'h0C000, 5'h00, 4'hE);
		sc_regions(1'b1);
		reg_write(EWSG_OFS_MULT, 16'hFFFE);
		reg_read(EWSG_OFS_MULT, d);
		`CHK("mult_clear", 16'h0000, d)
		acc_chk(EWSG_SP_IO, 20'h00001, 5'h00, 4'h1);
	endtask

	task automatic sc_ready_stall();
		reg_write(EWSG_OFS_REGION, 16'h14E5);
		acc_chk(EWSG_SP_DATA, 20'h09000, 5'h06, 4'h2);
		acc_chk(EWSG_SP_IO, 20'h00000, 5'h10, 4'h1);
		acc_chk(2'h3, 20'h00000, 5'h00, 4'h1);
		reg_write(EWSG_OFS_REGION, 16'h0000);
		acc_chk(EWSG_SP_PROG, 20'h00100, 5'h04, 4'h0);
	endtask

	// Reset in mid-run returns both registers to their reset values
	task automatic sc_mid_reset();
		logic [EWSG_DW-1:0] d;
		reg_write(EWSG_OFS_MULT, 16'h0001);
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		reg_read(EWSG_OFS_REGION, d);
		`CHK("region_rereset", 16'h7FFF, d)
		reg_read(EWSG_OFS_MULT, d);
		`CHK("mult_rereset", 16'h0000, d)
	endtask

	task automatic sc_clock_gate();
		logic [EWSG_DW-1:0] d;
		reg_write(EWSG_OFS_REGION, 16'h0000);
		@(posedge sys_clk);
		#1;
		`CHK("gate_all_zero", 1'b0, clk_active)
		acc_chk(EWSG_SP_DATA, 20'h08000, 5'h00, 4'h0);
		reg_write(EWSG_OFS_REGION, 16'h8038);
		@(posedge sys_clk);
		#1;
		`CHK("gate_unused_field", 1'b0, clk_active)
		reg_write(EWSG_OFS_REGION, 16'h0038);
		@(posedge sys_clk);
		#1;
		`CHK("gate_on", 1'b1, clk_active)
		reg_read(8'h29, d);
		`CHK("unmapped_read", 16'h0000, d)
	endtask

	// ==================================================
	// Main sequence: inputs set at time zero, reset for 20 cycles
	initial begin
		bad_count  = 0;
		n_compared = 0;
		arst_n     = 1'b0;
		reg_addr   = '0;
		reg_wdata  = '0;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		acc_start  = 1'b0;
		acc_space  = EWSG_SP_PROG;
		acc_addr   = '0;
		need       = 5'h00;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		sc_reset_state();
		sc_regions(1'b0);
		sc_doubler();
		sc_ready_stall();
		sc_mid_reset();
		sc_clock_gate();
		complete_run();
	end

	// Watchdog, far beyond the few hundred cycles the scenarios need
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		complete_run();
	end

endmodule

// ==== ewsg_wait_counter.sv ====
// Per-access wait counter: counts machine cycles, then waits for ready.
// Assumes start pulses come from the core and ready is synchronous.
`timescale 1ns/100ps

module ewsg_wait_counter #(
	parameter int CW = ewsg_pkg::EWSG_CW
) (
	// Clock and reset
	input  wire logic          clk_in,
	input  wire logic          arst_n_in,
	// Access request
	input  wire logic          start_in,
	input  wire logic [CW-1:0] count_in,
	input  wire logic          ready_in,
	// Access status
	output logic               busy_out,
	output logic               done_out
);
	import ewsg_pkg::*;

	typedef enum logic [1:0] {EWSG_ST_IDLE, EWSG_ST_WAIT, EWSG_ST_READY} ewsg_state_t;

	ewsg_state_t    state_r;
	logic [CW-1:0]  cnt_r;

	// ==================================================
	// Sequencer
	// Busy covers one base cycle plus every wait cycle plus ready stretch
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r  <= EWSG_ST_IDLE;
			cnt_r    <= '0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			unique case (state_r)
				EWSG_ST_IDLE: begin
					if (start_in) begin
						cnt_r    <= count_in;
						busy_out <= 1'b1;
						state_r  <= (count_in == '0) ? EWSG_ST_READY : EWSG_ST_WAIT;
					end
				end
				EWSG_ST_WAIT: begin
					cnt_r <= cnt_r - 1'b1;
					if (cnt_r == CW'(1)) begin
						state_r <= EWSG_ST_READY;
					end
				end
				EWSG_ST_READY: begin
					// External device may stretch beyond the programmed count
					if (ready_in) begin
						done_out <= 1'b1;
						busy_out <= 1'b0;
						state_r  <= EWSG_ST_IDLE;
					end
				end
			endcase
		end
	end

	// ==================================================
	// Checks
	sequence s_start2;
		start_in && !busy_out && count_in == CW'(2);
	endsequence

	a_count_holds_bus: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		s_start2 |=> busy_out [*3])
		else $error("bus cycle released before wait count expired");

	a_ready_extends: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(state_r == EWSG_ST_READY && !ready_in) |=> (busy_out && !done_out))
		else $error("access ended while ready was low");

endmodule
